//--- src/eed_pkg.sv
// shared constants, register map and carrier types of the edge event detector
package eed_pkg;
    // line counts and pin routing
    localparam int EED_LINES = 23;
    localparam int EED_EXT_LINES = 16;
    localparam int EED_INT_LINES = 7;
    localparam int EED_PINS = 140;
    localparam int EED_SEL_W = 8;
    localparam int EED_ADDR_W = 8;
    localparam int EED_SYNC_STAGES = 3;
    // register byte offsets
    localparam logic [7:0] EED_IMASK_OFF = 8'h00;
    localparam logic [7:0] EED_EMASK_OFF = 8'h04;
    localparam logic [7:0] EED_RISE_OFF = 8'h08;
    localparam logic [7:0] EED_FALL_OFF = 8'h0C;
    localparam logic [7:0] EED_PEND_OFF = 8'h10;
    localparam logic [7:0] EED_SRC_BASE = 8'h40;
    localparam logic [7:0] EED_SRC_LAST = 8'h7C;
    // reset values
    localparam logic [22:0] EED_MASK_RST = 23'h000000;
    localparam logic [22:0] EED_EDGE_RST = 23'h000000;
    localparam logic [7:0] EED_SEL_RST = 8'h00;
    // bus answers
    localparam logic [1:0] EED_RESP_OKAY = 2'h0;
    localparam logic [1:0] EED_RESP_SLVERR = 2'h2;
    // edges seen on one line in one cycle
    typedef struct packed {
        logic rise;
        logic fall;
    } eed_edge_t;
    // buffered write request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } eed_wreq_t;
endpackage

//--- src/eed_edge_catch.sv
// one detector line: clockless edge capture and resync to sys_clk
`timescale 1ns/1ps
module eed_edge_catch
    import eed_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic line_in,
    output eed_edge_t edge_o
);
    logic rise_tgl_reg;
    logic fall_tgl_reg;
    logic [EED_SYNC_STAGES-1:0] rise_sync_reg;
    logic [EED_SYNC_STAGES-1:0] fall_sync_reg;

    // R5: edge-clocked toggles
    // the line itself clocks the toggles, so a pulse shorter than a
    // sys_clk period still flips them; no sampling window can miss it
    always_ff @(posedge line_in or posedge sys_rst) begin
        if (sys_rst) rise_tgl_reg <= 1'b0;
        else rise_tgl_reg <= ~rise_tgl_reg;
    end

    always_ff @(negedge line_in or posedge sys_rst) begin
        if (sys_rst) fall_tgl_reg <= 1'b0;
        else fall_tgl_reg <= ~fall_tgl_reg;
    end

    // two-stage synchroniser plus one stage for change detection
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rise_sync_reg <= '0;
            fall_sync_reg <= '0;
        end else begin
            rise_sync_reg <= {rise_sync_reg[EED_SYNC_STAGES-2:0], rise_tgl_reg};
            fall_sync_reg <= {fall_sync_reg[EED_SYNC_STAGES-2:0], fall_tgl_reg};
        end
    end

    // toggle change after resync means one edge happened
    assign edge_o.rise = rise_sync_reg[EED_SYNC_STAGES-1] ^ rise_sync_reg[EED_SYNC_STAGES-2];
    assign edge_o.fall = fall_sync_reg[EED_SYNC_STAGES-1] ^ fall_sync_reg[EED_SYNC_STAGES-2];

    // R5: short pulse reported
    a_pulse_caught: assert property (@(posedge sys_clk) disable iff (sys_rst) // R5
        (rise_tgl_reg != rise_sync_reg[EED_SYNC_STAGES-1]) |-> ##[0:3] edge_o.rise)
        else $error("rising toggle not reported within three cycles");
endmodule

//--- src/eed_top.sv
// edge event detector: 23 lines, pin routing, pending bits, AXI4-Lite registers
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// R1: there are 23 independent detector lines, each able to raise an interrupt or an event.
// R2: each line selects rising, falling or both edges on its own.
// R3: each line has its own masks, and a masked line forwards nothing.
// R4: each line keeps a pending bit set by its selected edge until software clears it.
// R5: pulses shorter than one clock period are still caught.
// R6: sixteen lines are external, each fed from one of 140 selectable pins.
// R7: writing one clears a pending bit, zero leaves it, and a same-cycle edge wins.
module eed_top
    import eed_pkg::*;
#(
    parameter int NUM_LINES = EED_LINES,
    parameter int NUM_EXT = EED_EXT_LINES,
    parameter int NUM_PINS = EED_PINS
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [EED_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [EED_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_PINS-1:0] ext_pin,
    input wire logic [NUM_LINES-NUM_EXT-1:0] int_src,
    output logic [NUM_LINES-1:0] irq_line,
    output logic [NUM_LINES-1:0] evt_line,
    output logic irq
);
    // elaboration checks: the register layout is fixed at 23 lines
    if (NUM_LINES != EED_LINES || NUM_EXT != EED_EXT_LINES) begin : g_bad_lines
        $error("line counts must match the register layout");
    end
    if (NUM_PINS > (1 << EED_SEL_W) || NUM_PINS < 1) begin : g_bad_pins
        $error("pin count does not fit the source selector");
    end

    // byte-lane merge, used by every writable register
    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    // source selector decode, shared by read and write paths
    function automatic logic src_hit(input logic [EED_ADDR_W-1:0] a);
        return a >= EED_SRC_BASE && a <= EED_SRC_LAST && a[1:0] == 2'h0;
    endfunction

    function automatic logic [3:0] src_idx(input logic [EED_ADDR_W-1:0] a);
        return 4'((a - EED_SRC_BASE) >> 2);
    endfunction

    logic [22:0] imask_reg, emask_reg, rise_reg, fall_reg, pend_reg;
    logic [22:0] pend_next;
    logic [EED_SEL_W-1:0] src_sel_reg [NUM_EXT];
    logic [NUM_LINES-1:0] line_raw, edge_hit, evt_reg;
    eed_edge_t line_edge [NUM_LINES];
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    eed_wreq_t wreq_reg;
    // all selectors side by side, so one check can watch them together
    wire [NUM_EXT*EED_SEL_W-1:0] src_flat;

    // R6: pin routing onto the external lines
    // the selector is a plain mux; software should mask a line while
    // re-routing it, since the switch itself may look like an edge
    genvar gi;
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
        if (gi < NUM_EXT) begin : g_ext
            assign line_raw[gi] = ext_pin[src_sel_reg[gi]];
            assign src_flat[gi*EED_SEL_W +: EED_SEL_W] = src_sel_reg[gi];
        end else begin : g_int
            assign line_raw[gi] = int_src[gi-NUM_EXT];
        end
        // R1: one detector per line
        eed_edge_catch u_catch (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .line_in(line_raw[gi]),
            .edge_o(line_edge[gi])
        );
        // R2: per-line edge choice
        assign edge_hit[gi] = (line_edge[gi].rise & rise_reg[gi])
                            | (line_edge[gi].fall & fall_reg[gi]);
    end

    // write channel: address and data accepted in either order
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire wr_do = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire [7:0] wa = wreq_reg.addr;
    wire wr_imask = wr_do && wa == EED_IMASK_OFF;
    wire wr_emask = wr_do && wa == EED_EMASK_OFF;
    wire wr_rise = wr_do && wa == EED_RISE_OFF;
    wire wr_fall = wr_do && wa == EED_FALL_OFF;
    wire wr_pend = wr_do && wa == EED_PEND_OFF;
    wire wr_src = wr_do && src_hit(wa);
    wire wr_ok = wr_imask | wr_emask | wr_rise | wr_fall | wr_pend | wr_src;
    wire [31:0] src_new = strb_merge({24'h000000, src_sel_reg[src_idx(wa)]},
                                     wreq_reg.data, wreq_reg.strb);
    wire src_legal = src_new < 32'(NUM_PINS);
    wire [31:0] pend_clr = strb_merge(32'h00000000, wreq_reg.data, wreq_reg.strb);

    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready = ~w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // R7: write-one-to-clear, a new edge wins over the clear
    assign pend_next = (pend_reg & ~(wr_pend ? pend_clr[22:0] : 23'h000000)) | edge_hit;

    // write handshake state
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= EED_RESP_OKAY;
            wreq_reg <= '0;
        end else begin
            if (aw_fire) wreq_reg.addr <= s_axi_awaddr;
            if (w_fire) wreq_reg.data <= s_axi_wdata;
            if (w_fire) wreq_reg.strb <= s_axi_wstrb;
            aw_full_reg <= wr_do ? 1'b0 : (aw_full_reg | aw_fire);
            w_full_reg <= wr_do ? 1'b0 : (w_full_reg | w_fire);
            if (wr_do) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? EED_RESP_OKAY : EED_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // merged write values, cut to the 23 implemented bits on purpose
    wire [22:0] imask_new = 23'(strb_merge(32'(imask_reg), wreq_reg.data, wreq_reg.strb));
    wire [22:0] emask_new = 23'(strb_merge(32'(emask_reg), wreq_reg.data, wreq_reg.strb));
    wire [22:0] rise_new = 23'(strb_merge(32'(rise_reg), wreq_reg.data, wreq_reg.strb));
    wire [22:0] fall_new = 23'(strb_merge(32'(fall_reg), wreq_reg.data, wreq_reg.strb));

    // R3: software-steered masks and edge selects
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            imask_reg <= EED_MASK_RST;
            emask_reg <= EED_MASK_RST;
            rise_reg <= EED_EDGE_RST;
            fall_reg <= EED_EDGE_RST;
        end else begin
            if (wr_imask) imask_reg <= imask_new;
            if (wr_emask) emask_reg <= emask_new;
            if (wr_rise) rise_reg <= rise_new;
            if (wr_fall) fall_reg <= fall_new;
        end
    end

    // R6: source selectors; an index past the last pin is dropped
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_EXT; i++) src_sel_reg[i] <= EED_SEL_RST;
        end else if (wr_src && src_legal) begin
            src_sel_reg[src_idx(wa)] <= src_new[EED_SEL_W-1:0];
        end
    end

    // R4: pending bits and event pulses
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_reg <= EED_MASK_RST;
            evt_reg <= '0;
        end else begin
            pend_reg <= pend_next;
            evt_reg <= edge_hit & emask_reg;
        end
    end

    // R3: interrupt gating per line, one level output
    assign irq_line = pend_reg & imask_reg;
    assign irq = |irq_line;
    assign evt_line = evt_reg;

    // read channel: one word per address, reads have no side effect
    wire ar_fire = s_axi_arvalid & s_axi_arready;
    wire [7:0] ra = s_axi_araddr;
    wire rd_src = src_hit(ra);
    wire rd_hit = ra == EED_IMASK_OFF || ra == EED_EMASK_OFF || ra == EED_RISE_OFF
                || ra == EED_FALL_OFF || ra == EED_PEND_OFF || rd_src;
    wire [22:0] rd_reg = (ra == EED_IMASK_OFF) ? imask_reg
                       : (ra == EED_EMASK_OFF) ? emask_reg
                       : (ra == EED_RISE_OFF) ? rise_reg
                       : (ra == EED_FALL_OFF) ? fall_reg
                       : (ra == EED_PEND_OFF) ? pend_reg
                       : rd_src ? 23'(src_sel_reg[src_idx(ra)]) : 23'h000000;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= EED_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {9'h000, rd_reg};
            rresp_reg <= rd_hit ? EED_RESP_OKAY : EED_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // checks on line behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_irq_summary: assert property (irq == |(pend_reg & imask_reg)) // R1
        else $error("interrupt output disagrees with pending and mask");
    a_edge_select: assert property ( // R2
        (edge_hit & ~(rise_reg | fall_reg)) == 23'h000000)
        else $error("edge reported on a line with no edge selected");
    a_evt_masked: assert property ( // R3
        ##1 evt_line == $past(edge_hit & emask_reg))
        else $error("event output ignores the event mask");
    a_pend_set: assert property ( // R4
        |edge_hit |=> (pend_reg & $past(edge_hit)) == $past(edge_hit))
        else $error("selected edge did not set its pending bit");
    a_pend_hold: assert property ( // R4
        (!wr_pend && edge_hit == 23'h000000) |=> $stable(pend_reg))
        else $error("pending bits moved without edge or clear");
    a_src_range: assert property ( // R6
        wr_src && !src_legal |=> $stable(src_flat))
        else $error("illegal pin index was stored");
    a_clear_w1c: assert property ( // R7
        wr_pend |=> pend_reg == (($past(pend_reg) & ~$past(pend_clr[22:0]))
                                 | $past(edge_hit)))
        else $error("pending clear wrong or edge lost");
    a_write_answer: assert property (wr_do |=> s_axi_bvalid ##0 s_axi_bresp == $past(
        wr_ok ? EED_RESP_OKAY : EED_RESP_SLVERR))
        else $error("write answer missing or wrong");

    c_pend_set: cover property (|edge_hit ##1 irq);
    c_clear_race: cover property (wr_pend && |(pend_clr[22:0] & edge_hit));
    c_read_pend: cover property (ar_fire && ra == EED_PEND_OFF);
    c_bad_addr: cover property (wr_do && !wr_ok);
endmodule

//--- sim/eed_pin_model.sv
// pin-side model: drives detector pins and counts event pulses
`timescale 1ns/1ps
module eed_pin_model
    import eed_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [EED_LINES-1:0] evt_line,
    output logic [EED_PINS-1:0] ext_pin,
    output logic [EED_INT_LINES-1:0] int_src
);
    logic [EED_PINS+EED_INT_LINES-1:0] pins;
    int evt_cnt [EED_LINES];
    // pins idle low; indices above the pin range feed the internal lines
    initial pins = '0;
    assign ext_pin = pins[EED_PINS-1:0];
    assign int_src = pins[EED_PINS+EED_INT_LINES-1:EED_PINS];
    // any pin index up to 146; indices 140 and above drive the internal lines
    task automatic flip(input int idx);
        pins[idx] <= ~pins[idx];
    endtask
    // pulse of 1 ns, well under the 4 ns clock, not clock aligned
    task automatic pulse(input int idx);
        flip(idx);
        #1;
        flip(idx);
    endtask
    // one count per cycle that an event line stands high
    always @(posedge sys_clk or posedge sys_rst) begin
        for (int i = 0; i < EED_LINES; i++) begin
            if (sys_rst)
                evt_cnt[i] <= 0;
            else if (evt_line[i] === 1'b1)
                evt_cnt[i] <= evt_cnt[i] + 1;
        end
    end
endmodule

//--- sim/test_edge_event_detector.sv
// self-checking bench: register access, edge modes, masks and pending clears
`timescale 1ns/1ps
module test_edge_event_detector
    import eed_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [3:0] strb_v = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] rdata, rd_v, pend_exp;
    logic [1:0] bresp, rresp, resp_v;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [EED_PINS-1:0] ext_pin;
    logic [EED_INT_LINES-1:0] int_src;
    logic [EED_LINES-1:0] irq_line, evt_line;
    int error_cnt = 0;
    int compares = 0;
    always #2 sys_clk = ~sys_clk;
    eed_top i_eed_top (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_pin(ext_pin), .int_src(int_src),
        .irq_line(irq_line), .evt_line(evt_line), .irq(irq));
    eed_pin_model i_eed_pin_model (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .evt_line(evt_line),
        .ext_pin(ext_pin), .int_src(int_src));
    // shared comparison, counts every call
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    // no cycle limit here: only the watchdog ends a wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb_v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp_v = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_v = rdata;
        resp_v = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, rd_v, e);
        chk("read resp", {30'h0, resp_v}, {30'h0, EED_RESP_OKAY});
    endtask
    // capture and resync take at most 4 edges; 8 leaves margin
    task automatic settle();
        repeat (8) @(posedge sys_clk);
    endtask
    // pending register, interrupt lines and summary against expectation
    task automatic chk_state(input logic [22:0] im);
        rd_chk(EED_PEND_OFF, pend_exp, "pending");
        chk("irq_line", {9'h0, irq_line}, pend_exp & {9'h0, im});
        chk("irq", {31'h0, irq}, {31'h0, |(pend_exp[22:0] & im)});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
    initial begin
        pend_exp = 32'h0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a <= 16; a += 4) begin
            rd_chk(8'(a), 32'h0, "reset value");
        end
        rd_chk(EED_SRC_BASE, 32'h0, "selector reset");
        // unmapped place: error answer, reads zero
        rd(8'h20);
        chk("unmapped read", rd_v, 32'h0);
        chk("unmapped rresp", {30'h0, resp_v}, {30'h0, EED_RESP_SLVERR});
        wr(8'h20, 32'hFFFF_FFFF);
        chk("unmapped bresp", {30'h0, resp_v}, {30'h0, EED_RESP_SLVERR});
        // lines 0..2 from pins 5, 139, 70; pin 140 does not exist
        wr(EED_SRC_BASE, 32'h5);
        wr(EED_SRC_BASE + 8'h4, 32'h8B);
        wr(EED_SRC_BASE + 8'h8, 32'h46);
        wr(EED_SRC_BASE + 8'h4, 32'h8C);
        chk("selector bresp", {30'h0, resp_v}, {30'h0, EED_RESP_OKAY});
        rd_chk(EED_SRC_BASE + 8'h4, 32'h8B, "selector kept");
        // line 0 rising, line 1 falling, line 2 both, line 16 rising
        wr(EED_RISE_OFF, 32'h0001_0005);
        wr(EED_FALL_OFF, 32'h0000_0006);
        wr(EED_IMASK_OFF, 32'hFFFF_FFFF);
        rd_chk(EED_IMASK_OFF, 32'h007F_FFFF, "imask width");
        // byte-lane merge: only lane 0 written, line 16 keeps rising
        strb_v = 4'h1;
        wr(EED_RISE_OFF, 32'h0000_0005);
        strb_v = 4'hF;
        rd_chk(EED_RISE_OFF, 32'h0001_0005, "rise lane merge");
        wr(EED_EMASK_OFF, 32'h007F_FFFF);
        #1.3;
        i_eed_pin_model.pulse(5);
        i_eed_pin_model.pulse(6);
        settle();
        pend_exp = 32'h1;
        chk_state(23'h7FFFFF);
        i_eed_pin_model.flip(139);
        i_eed_pin_model.flip(70);
        settle();
        pend_exp = 32'h5;
        chk_state(23'h7FFFFF);
        i_eed_pin_model.flip(139);
        i_eed_pin_model.flip(70);
        i_eed_pin_model.pulse(140);
        settle();
        pend_exp = 32'h0001_0007;
        chk_state(23'h7FFFFF);
        chk("line 2 events", i_eed_pin_model.evt_cnt[2], 32'h2);
        // masking line 2 leaves the others forwarding
        wr(EED_IMASK_OFF, 32'h007F_FFFB);
        chk_state(23'h7FFFFB);
        wr(EED_PEND_OFF, 32'h1);
        pend_exp = 32'h0001_0006;
        chk_state(23'h7FFFFB);
        wr(EED_PEND_OFF, 32'h0);
        chk_state(23'h7FFFFB);
        // event mask off on line 0: pending sets, no event pulse
        wr(EED_EMASK_OFF, 32'h007F_FFFE);
        i_eed_pin_model.pulse(5);
        settle();
        pend_exp = 32'h0001_0007;
        chk_state(23'h7FFFFB);
        chk("line 0 events", i_eed_pin_model.evt_cnt[0], 32'h1);
        wr(EED_PEND_OFF, 32'hFFFF_FFFF);
        pend_exp = 32'h0;
        chk_state(23'h7FFFFB);
        final_report();
    end
endmodule
